// *** wdt_pkg.sv ***
// Purpose: Shared constants, types and decoding for the I/O port watchdog.
// Assumes: 125 MHz reference clock; host I/O cycles arrive on asynchronous pins.
// Notes: The timeout table and the pulse length are plain defaults.
// How it works
// - A read of the refresh port while disabled enables the watchdog and starts counting.
// - Each refresh-port read while running restarts the count from the full period.
// - Any read of the disable port stops the count and disables the watchdog.
// - On expiry drive either system reset or NMI, per the action select input.
// - The countdown length comes from the static period select inputs.
package wdt_pkg;

   // Clock and time base
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned FIRE_US = 100;

   // Host I/O port map
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam logic [15:0] DISABLE_PORT = 16'h0043;
   localparam logic [15:0] REFRESH_PORT = 16'h0443;

   // Status byte returned by a read of either port
   localparam int unsigned STAT_RUNNING_BIT = 0;
   localparam int unsigned STAT_ACTION_BIT = 1;
   localparam logic [7:0] STAT_RESET = 8'h00;

   // Select inputs
   localparam int unsigned PSEL_W = 3;
   localparam logic ACTION_RESET = 1'b0;
   localparam logic ACTION_NMI = 1'b1;

   // Counter widths
   localparam int unsigned WD_W = 16;
   localparam int unsigned PRE_W = 20;

   // Timeout periods in milliseconds, one per period select code
   localparam logic [15:0] PERIOD_MS_0 = 16'h03e8;
   localparam logic [15:0] PERIOD_MS_1 = 16'h07d0;
   localparam logic [15:0] PERIOD_MS_2 = 16'h1388;
   localparam logic [15:0] PERIOD_MS_3 = 16'h2710;
   localparam logic [15:0] PERIOD_MS_4 = 16'h4e20;
   localparam logic [15:0] PERIOD_MS_5 = 16'h7530;
   localparam logic [15:0] PERIOD_MS_6 = 16'hafc8;
   localparam logic [15:0] PERIOD_MS_7 = 16'hea60;

   // Watchdog states
   typedef enum logic [1:0] {
      WD_DISABLED,
      WD_RUNNING,
      WD_FIRING
   } wd_state_t;

   // One decoded host read
   typedef struct packed {
      logic start;
      logic [15:0] addr;
   } io_req_t;

   // Period select code to period in milliseconds
   function automatic logic [15:0] period_ticks(input logic [2:0] sel);
      logic [15:0] p;
      p = PERIOD_MS_0;
      unique case (sel)
         3'h0: p = PERIOD_MS_0;
         3'h1: p = PERIOD_MS_1;
         3'h2: p = PERIOD_MS_2;
         3'h3: p = PERIOD_MS_3;
         3'h4: p = PERIOD_MS_4;
         3'h5: p = PERIOD_MS_5;
         3'h6: p = PERIOD_MS_6;
         3'h7: p = PERIOD_MS_7;
      endcase
      return p;
   endfunction : period_ticks

endpackage : wdt_pkg

// *** io_port_watchdog_timer.sv ***
// Purpose: Watchdog driven only by host reads of two I/O ports.
// Assumes: I/O strobe, address and select jumpers are asynchronous pins.
// Notes: After firing the watchdog falls back to disabled until re-enabled.
`timescale 1ns/1ps
module io_port_watchdog_timer #(
   parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_US * wdt_pkg::CLK_MHZ,
   parameter int unsigned FIRE_CYCLES = wdt_pkg::FIRE_US * wdt_pkg::CLK_MHZ
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Host I/O bus pins
   input wire logic io_rd_n_i,
   input wire logic [15:0] io_addr_i,
   input wire logic [7:0] io_data_i,
   output logic [7:0] io_data_o,
   output logic io_data_oe_o,
   // Static jumper inputs
   input wire logic timeout_action_select_i,
   input wire logic [2:0] timeout_period_select_i,
   // Expiry actions and status
   output logic sys_reset_o,
   output logic nmi_o,
   output logic wd_running_o
);

   // Synchroniser stages for the pins
   logic rd_meta;
   logic rd_sync;
   logic rd_prev;
   logic [15:0] addr_meta;
   logic [15:0] addr_sync;
   logic act_meta;
   logic act_sync;
   logic [2:0] psel_meta;
   logic [2:0] psel_sync;

   // Core state
   wdt_pkg::wd_state_t state;
   wdt_pkg::wd_state_t next_state;
   logic [19:0] pre_cnt;
   logic [19:0] next_pre_cnt;
   logic [15:0] wd_cnt;
   logic [15:0] next_wd_cnt;
   wdt_pkg::io_req_t req;

   // Decode wires
   wire rd_start;
   wire refresh_hit;
   wire disable_hit;
   wire load;
   wire tick;
   wire expire;
   wire fire_done;
   wire port_hit;
   wire [7:0] status_byte;
   wire next_reset;
   wire next_nmi;
   wire [7:0] io_unused;

   // Two flops on every pin before any logic looks at it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_meta <= 1'b1;
         rd_sync <= 1'b1;
         rd_prev <= 1'b1;
         addr_meta <= 16'h0000;
         addr_sync <= 16'h0000;
         act_meta <= 1'b0;
         act_sync <= 1'b0;
         psel_meta <= 3'h0;
         psel_sync <= 3'h0;
      end else begin
         rd_meta <= io_rd_n_i;
         rd_sync <= rd_meta;
         rd_prev <= rd_sync;
         addr_meta <= io_addr_i;
         addr_sync <= addr_meta;
         act_meta <= timeout_action_select_i;
         act_sync <= act_meta;
         psel_meta <= timeout_period_select_i;
         psel_sync <= psel_meta;
      end
   end

   // Read cycle start and port decode
   assign io_unused = io_data_i;
   assign rd_start = rd_prev & ~rd_sync;
   assign req = '{start: rd_start, addr: addr_sync};
   assign refresh_hit = req.start && (req.addr == wdt_pkg::REFRESH_PORT);
   assign disable_hit = req.start && (req.addr == wdt_pkg::DISABLE_PORT);
   assign port_hit = ~rd_sync && ((addr_sync == wdt_pkg::REFRESH_PORT) ||
                                  (addr_sync == wdt_pkg::DISABLE_PORT));

   // Refresh loads the counter unless a disable read coincides or mid-action
   assign load = refresh_hit && !disable_hit && (state != wdt_pkg::WD_FIRING);
   assign tick = (state == wdt_pkg::WD_RUNNING) && (pre_cnt == 20'(TICK_CYCLES - 1));
   assign expire = tick && (wd_cnt == 16'h0001);
   assign fire_done = (state == wdt_pkg::WD_FIRING) && (pre_cnt == 20'(FIRE_CYCLES - 1));

   // State sequencing, disable read takes priority
   always_comb begin
      next_state = state;
      if (disable_hit) begin
         next_state = wdt_pkg::WD_DISABLED;
      end else begin
         unique case (state)
            wdt_pkg::WD_DISABLED: begin
               if (refresh_hit) begin
                  next_state = wdt_pkg::WD_RUNNING;
               end
            end
            wdt_pkg::WD_RUNNING: begin
               if (expire && !load) begin
                  next_state = wdt_pkg::WD_FIRING;
               end
            end
            wdt_pkg::WD_FIRING: begin
               if (fire_done) begin
                  next_state = wdt_pkg::WD_DISABLED;
               end
            end
         endcase
      end
   end

   // Prescaler restarts on each load so a period is exact
   assign next_pre_cnt = (load || tick || (next_state != state) ||
                          (state == wdt_pkg::WD_DISABLED)) ? 20'h00000 : pre_cnt + 20'h00001;
   assign next_wd_cnt = load ? wdt_pkg::period_ticks(psel_sync) :
                        (tick ? wd_cnt - 16'h0001 : wd_cnt);

   // Expiry actions follow the action jumper
   assign next_reset = (next_state == wdt_pkg::WD_FIRING) &&
                       (act_sync == wdt_pkg::ACTION_RESET);
   assign next_nmi = (next_state == wdt_pkg::WD_FIRING) &&
                     (act_sync == wdt_pkg::ACTION_NMI);

   // Status byte for host reads
   assign status_byte = wdt_pkg::STAT_RESET |
                        (8'(state == wdt_pkg::WD_RUNNING) << wdt_pkg::STAT_RUNNING_BIT) |
                        (8'(act_sync) << wdt_pkg::STAT_ACTION_BIT);

   // Core registers, disabled and quiet from reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= wdt_pkg::WD_DISABLED;
         pre_cnt <= 20'h00000;
         wd_cnt <= 16'h0000;
         sys_reset_o <= 1'b0;
         nmi_o <= 1'b0;
         wd_running_o <= 1'b0;
      end else begin
         state <= next_state;
         pre_cnt <= next_pre_cnt;
         wd_cnt <= next_wd_cnt;
         sys_reset_o <= next_reset;
         nmi_o <= next_nmi;
         wd_running_o <= (next_state == wdt_pkg::WD_RUNNING);
      end
   end

   // Data bus drive while a read to either port is in progress
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_data_o <= 8'h00;
         io_data_oe_o <= 1'b0;
      end else begin
         io_data_o <= port_hit ? status_byte : 8'h00;
         io_data_oe_o <= port_hit;
      end
   end

   // Helpers for timing checks
   logic [39:0] elapsed;
   logic [15:0] loaded_ticks;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         elapsed <= 40'h0;
         loaded_ticks <= 16'h0000;
      end else begin
         elapsed <= load ? 40'h1 : elapsed + 40'h1;
         loaded_ticks <= load ? next_wd_cnt : loaded_ticks;
      end
   end

   // Checks
   a_enable_on_read: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_DISABLED) && refresh_hit |=>
      (state == wdt_pkg::WD_RUNNING) && wd_running_o)
      else $error("refresh read did not enable watchdog");

   a_refresh_reload: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_RUNNING) && refresh_hit |=>
      (wd_cnt == wdt_pkg::period_ticks($past(psel_sync))) && (pre_cnt == 20'h00000))
      else $error("refresh read did not restart the count");

   a_disable_read: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      disable_hit |=> (state == wdt_pkg::WD_DISABLED) && !sys_reset_o && !nmi_o && !wd_running_o)
      else $error("disable read did not stop watchdog");

   a_reset_action: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_FIRING) && !$past(act_sync) |-> sys_reset_o && !nmi_o)
      else $error("reset action not driven on expiry");

   a_nmi_action: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_FIRING) && $past(act_sync) |-> nmi_o && !sys_reset_o)
      else $error("nmi action not driven on expiry");

   a_expiry_time: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_FIRING) && ($past(state) == wdt_pkg::WD_RUNNING) |->
      elapsed == (40'(loaded_ticks) * 40'(TICK_CYCLES)) + 40'h1)
      else $error("expiry not at selected period");

   a_quiet_disabled: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_DISABLED) |-> !sys_reset_o && !nmi_o)
      else $error("action driven while disabled");

   a_fire_bounded: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == wdt_pkg::WD_FIRING) |-> (pre_cnt < 20'(FIRE_CYCLES)) && (sys_reset_o || nmi_o))
      else $error("action pulse overran its length");

endmodule : io_port_watchdog_timer

// *** host_io_model.sv ***
// Purpose: Host side of the I/O bus, issuing single port reads.
// Assumes: Strobe and address change 1 ns after a rising clock edge.
// Notes: A released data bus shows a pattern that flips every cycle; bus looked at 1 ns after edges.
`timescale 1ns/1ps
module host_io_model (
   // Clock
   input wire logic ref_clk_i,
   // Block's data bus drive
   input wire logic [7:0] io_data_i,
   input wire logic io_data_oe_i,
   // Host bus drive and resolved data bus
   output logic io_rd_n_o,
   output logic [15:0] io_addr_o,
   output logic [7:0] bus_o
);
   logic [7:0] last = 8'h00;

   // Undriven bus never repeats the last byte
   assign bus_o = io_data_oe_i ? io_data_i : ~last;
   always @(posedge ref_clk_i) last <= bus_o;

   initial begin
      io_rd_n_o = 1'b1;
      io_addr_o = 16'h0000;
   end

   // One read: strobe low 6 cycles, byte taken once settled after each edge
   task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic seen);
      seen = 1'b0;
      d = 8'h00;
      @(posedge ref_clk_i);
      #1;
      io_rd_n_o = 1'b0;
      io_addr_o = a;
      repeat (6) begin
         @(posedge ref_clk_i);
         #1;
         if (io_data_oe_i === 1'b1) begin
            seen = 1'b1;
            d = bus_o;
         end
      end
      io_rd_n_o = 1'b1;
      io_addr_o = ~a; // Address wanders once the strobe is gone
      repeat (3) @(posedge ref_clk_i);
   endtask : io_read
endmodule : host_io_model

// *** test_io_port_watchdog_timer.sv ***
// Purpose: Self-checking bench for the I/O port watchdog.
// Assumes: Short tick and pulse parameters keep the run brief.
// Notes: Expiry time is measured from the start of the enabling read.
`timescale 1ns/1ps
module test_io_port_watchdog_timer;
   localparam int unsigned TICK = 4;
   localparam int unsigned FIRE = 3;
   logic ref_clk_i, rst_n_i, act, rd_n, oe, sres, nmi, run, seen;
   logic [2:0] psel;
   logic [15:0] addr;
   logic [7:0] dout, bus, d;
   int err_count, n_checks, cyc;
   time t0;

   io_port_watchdog_timer #(.TICK_CYCLES(TICK), .FIRE_CYCLES(FIRE)) u_io_port_watchdog_timer (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_rd_n_i(rd_n), .io_addr_i(addr),
      .io_data_i(bus), .io_data_o(dout), .io_data_oe_o(oe), .timeout_action_select_i(act),
      .timeout_period_select_i(psel), .sys_reset_o(sres), .nmi_o(nmi), .wd_running_o(run));
   host_io_model u_host_io_model (.ref_clk_i(ref_clk_i), .io_data_i(dout),
      .io_data_oe_i(oe), .io_rd_n_o(rd_n), .io_addr_o(addr), .bus_o(bus));

   // Clock at 125 MHz
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out

   // Wait n cycles with neither expiry action seen
   task automatic quiet(input int n);
      logic hit;
      hit = 1'b0;
      repeat (n) begin
         @(posedge ref_clk_i);
         #1;
         if (sres !== 1'b0 || nmi !== 1'b0) hit = 1'b1;
      end
      chk(!hit, "unexpected expiry action");
   endtask : quiet

   // Port read with expected drive and status byte
   task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic eoe);
      u_host_io_model.io_read(a, d, seen);
      chk(seen === eoe, "data bus drive");
      if (eoe) chk(d === ed, "status byte");
   endtask : rd

   // Enable, then let the countdown run out
   task automatic expire(input logic a, input logic [2:0] ps, input int p);
      @(posedge ref_clk_i);
      #1;
      act = a;
      psel = ps;
      repeat (4) @(posedge ref_clk_i);
      #1;
      t0 = $time;
      rd(wdt_pkg::REFRESH_PORT, {6'h00, a, 1'b1}, 1'b1);
      cyc = 0;
      while (sres !== 1'b1 && nmi !== 1'b1 && cyc < p + 50) begin
         @(posedge ref_clk_i);
         #1;
         cyc++;
      end
      cyc = int'(($time - t0) / 8);
      chk(cyc >= p && cyc <= p + 8, "expiry time");
      chk(sres === (a == wdt_pkg::ACTION_RESET) && nmi === (a == wdt_pkg::ACTION_NMI), "action");
      chk(run === 1'b0, "running during action");
      if (sres !== 1'b1 && nmi !== 1'b1) close_out();
      // Pulse still up one cycle before its end
      repeat (FIRE - 1) @(posedge ref_clk_i);
      #1;
      chk(sres === (a == wdt_pkg::ACTION_RESET) && nmi === (a == wdt_pkg::ACTION_NMI), "pulse short");
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk(sres === 1'b0 && nmi === 1'b0 && run === 1'b0, "action pulse end");
   endtask : expire

   // Main sequence
   initial begin
      err_count = 0;
      n_checks = 0;
      rst_n_i = 1'b0;
      act = wdt_pkg::ACTION_RESET;
      psel = 3'h0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      chk(sres === 1'b0 && nmi === 1'b0 && run === 1'b0 && oe === 1'b0, "reset state");
      quiet(5000);
      rd(16'h0143, 8'h00, 1'b0);
      chk(run === 1'b0, "foreign port enabled");
      rd(wdt_pkg::REFRESH_PORT, 8'h01, 1'b1);
      chk(run === 1'b1, "not running");
      // Refresh at about 70 percent of the period
      repeat (2) begin
         quiet(2800);
         rd(wdt_pkg::REFRESH_PORT, 8'h01, 1'b1);
      end
      rd(wdt_pkg::DISABLE_PORT, 8'h00, 1'b1);
      chk(run === 1'b0, "still running");
      quiet(5000);
      expire(wdt_pkg::ACTION_RESET, 3'h0, int'(wdt_pkg::PERIOD_MS_0) * TICK);
      expire(wdt_pkg::ACTION_RESET, 3'h2, int'(wdt_pkg::PERIOD_MS_2) * TICK);
      expire(wdt_pkg::ACTION_NMI, 3'h1, int'(wdt_pkg::PERIOD_MS_1) * TICK);
      rd(wdt_pkg::REFRESH_PORT, 8'h03, 1'b1);
      rd(wdt_pkg::DISABLE_PORT, 8'h02, 1'b1);
      quiet(9000);
      // Reset in mid-count leaves the watchdog disabled and quiet
      rd(wdt_pkg::REFRESH_PORT, 8'h03, 1'b1);
      @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      chk(sres === 1'b0 && nmi === 1'b0 && run === 1'b0 && oe === 1'b0, "mid-run reset");
      quiet(9000);
      close_out();
   end
endmodule : test_io_port_watchdog_timer
